// >>> core/ddr_pkg.sv
// Shared constants and types of the memory command link
package ddr_pkg;
   localparam int ADDR_W = 13;
   localparam int DQ_W = 64;
   localparam int LANES = 8;
   localparam int AUTOPRE_POS = 10;
   localparam int MEM_N = 16;
   // Command codes as {row strobe, column strobe, write enable}
   localparam logic [2:0] CMD_LMR = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_NOP = 3'h7;
   // Link clock phases, four pclk cycles per link clock
   localparam logic [1:0] PH_LOAD = 2'h1;
   localparam logic [1:0] PH_BEAT0 = 2'h3;
   localparam logic [1:0] PH_STB_HI = 2'h0;
   localparam logic [1:0] PH_BEAT1 = 2'h1;
   localparam logic [1:0] PH_STB_LO = 2'h2;
   // Controller register offsets
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_CTRL = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0c;
   localparam logic [7:0] REG_WD0 = 8'h10;
   localparam logic [7:0] REG_RD0 = 8'h20;
   localparam logic [7:0] REG_MASK = 8'h30;
   // Field positions
   localparam int CMD_BANK_LSB = 3;
   localparam int CMD_DESEL_BIT = 5;
   localparam int CTRL_CKE_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_RDONE_BIT = 1;
   localparam int STAT_CKE_BIT = 2;
   // Reset values
   localparam logic CKE_RST = 1'b1;
   localparam logic [5:0] CMD_REG_RST = 6'h07;
   localparam logic [12:0] MODE_RST = 13'h0000;
   typedef enum logic [1:0] {P_ON, P_PD_PRE, P_PD_ACT, P_SELF} pwr_t;
   typedef enum logic [1:0] {C_IDLE, C_CMD, C_WR, C_RD} cst_t;
endpackage

// >>> core/ddr_link_if.sv
// Pin bundle between memory controller and memory module
`timescale 1ns/1ps
interface ddr_link_if;
   logic        sys_clk_p;
   logic        sys_clk_n;
   logic        clk_gate_in;
   logic        chip_sel_n;
   logic        row_strobe_n;
   logic        col_strobe_n;
   logic        write_en_n;
   logic        bank_sel_lo;
   logic        bank_sel_hi;
   logic [12:0] addr;
   logic [63:0] dq_ctl_o;
   logic [7:0]  dq_ctl_oe;
   logic [63:0] dq_dev_o;
   logic [7:0]  dq_dev_oe;
   logic [63:0] data_lines;
   logic [7:0]  dqs_ctl_o;
   logic [7:0]  dqs_ctl_oe;
   logic [7:0]  dqs_dev_o;
   logic [7:0]  dqs_dev_oe;
   logic [7:0]  data_strobes;
   logic [7:0]  write_byte_masks;
   // Wire levels from the enables, idle lanes read low
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         data_lines[8*i +: 8] = dq_ctl_oe[i] ? dq_ctl_o[8*i +: 8] : (dq_dev_oe[i] ? dq_dev_o[8*i +: 8] : 8'h00);
         data_strobes[i] = dqs_ctl_oe[i] ? dqs_ctl_o[i] : (dqs_dev_oe[i] & dqs_dev_o[i]);
      end
   end
   modport ctrl (output sys_clk_p, sys_clk_n, clk_gate_in, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n,
                 bank_sel_lo, bank_sel_hi, addr, dq_ctl_o, dq_ctl_oe, dqs_ctl_o, dqs_ctl_oe, write_byte_masks,
                 input data_lines, data_strobes);
   modport dev (input sys_clk_p, sys_clk_n, clk_gate_in, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n,
                bank_sel_lo, bank_sel_hi, addr, write_byte_masks, data_lines, data_strobes,
                output dq_dev_o, dq_dev_oe, dqs_dev_o, dqs_dev_oe);
endinterface

// >>> core/ddr_cross_det.sv
// Crossing detector of a differential clock pair
`timescale 1ns/1ps
module ddr_cross_det (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Clock pair
   input  wire logic clk_p,
   input  wire logic clk_n,
   // Crossing pulses
   output logic      rise_q,
   output logic      fall_q
);
   typedef struct packed {
      logic p;
      logic n;
      logic rise;
      logic fall;
   } det_t;
   det_t s_q;
   det_t s_d;
   always_comb
   begin
      s_d = s_q;
      s_d.p = clk_p;
      s_d.n = clk_n;
      s_d.rise = clk_p & ~clk_n & ~s_q.p & s_q.n;
      s_d.fall = ~clk_p & clk_n & s_q.p & ~s_q.n;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end
   assign rise_q = s_q.rise;
   assign fall_q = s_q.fall;
endmodule

// >>> core/ddr_module_end.sv
// Memory module end: command decode, power states, strobed data
`timescale 1ns/1ps
module ddr_module_end (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Link
   ddr_link_if.dev           link,
   // Status
   output ddr_pkg::pwr_t     pwr_state,
   output logic [3:0]        open_banks,
   output logic [12:0]       base_mode,
   output logic [12:0]       ext_mode,
   output logic [2:0]        last_cmd
);
   typedef struct packed {
      ddr_pkg::pwr_t     pwr;
      logic [3:0]        open;
      logic [12:0]       mode_base;
      logic [12:0]       mode_ext;
      logic [2:0]        last;
      logic [1:0]        rd_st;
      logic [1:0]        wr_st;
      logic [1:0]        bank;
      logic [1:0]        col;
      logic              ap;
      logic              dqs_prev;
      logic [63:0]       dq_o;
      logic [7:0]        dq_oe;
      logic [7:0]        dqs_o;
      logic [7:0]        dqs_oe;
      logic [15:0][63:0] mem;
   } dev_t;
   dev_t s_q;
   dev_t s_d;
   logic       rise;
   logic       fall;
   logic [2:0] cmd;
   logic [1:0] ba;
   logic       stb_rise;
   logic       stb_fall;

   function automatic logic [3:0] mem_idx(input logic [1:0] b, input logic [1:0] c, input logic beat);
      mem_idx = {b, c[1], c[0] ^ beat};
   endfunction

   ddr_cross_det u_det (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_p   (link.sys_clk_p),
      .clk_n   (link.sys_clk_n),
      .rise_q  (rise),
      .fall_q  (fall)
   );

   assign cmd = {link.row_strobe_n, link.col_strobe_n, link.write_en_n};
   assign ba = {link.bank_sel_hi, link.bank_sel_lo};
   assign stb_rise = link.data_strobes[0] & ~s_q.dqs_prev;
   assign stb_fall = ~link.data_strobes[0] & s_q.dqs_prev;

   always_comb
   begin
      s_d = s_q;
      s_d.dqs_prev = link.data_strobes[0];
      // Write beats taken on the controller's centred strobe edges
      if ((s_q.wr_st == 2'h1 && stb_rise) || (s_q.wr_st == 2'h2 && stb_fall))
      begin
         for (int i = 0; i < ddr_pkg::LANES; i++)
         begin
            if (!link.write_byte_masks[i])
               s_d.mem[mem_idx(s_q.bank, s_q.col, s_q.wr_st[1])][8*i +: 8] = link.data_lines[8*i +: 8];
         end
         s_d.wr_st = (s_q.wr_st == 2'h1) ? 2'h2 : 2'h0;
         if (s_q.wr_st == 2'h2 && s_q.ap)
            s_d.open[s_q.bank] = 1'b0;
      end
      // Read burst, data and strobe change together at crossings
      if (rise && s_q.rd_st == 2'h3)
      begin
         s_d.dq_oe = 8'h00;
         s_d.dqs_oe = 8'h00;
         s_d.dqs_o = 8'h00;
         s_d.rd_st = 2'h0;
         if (s_q.ap)
            s_d.open[s_q.bank] = 1'b0;
      end
      else if (rise && s_q.rd_st == 2'h1)
      begin
         s_d.dq_o = s_q.mem[mem_idx(s_q.bank, s_q.col, 1'b0)];
         s_d.dq_oe = 8'hff;
         s_d.dqs_o = 8'hff;
         s_d.dqs_oe = 8'hff;
         s_d.rd_st = 2'h2;
      end
      else if (fall && s_q.rd_st == 2'h2)
      begin
         s_d.dq_o = s_q.mem[mem_idx(s_q.bank, s_q.col, 1'b1)];
         s_d.dqs_o = 8'h00;
         s_d.rd_st = 2'h3;
      end
      case (s_q.pwr)
         ddr_pkg::P_ON:
         begin
            if (rise && !link.clk_gate_in)
            begin
               if (!link.chip_sel_n && cmd == ddr_pkg::CMD_REF)
                  s_d.pwr = ddr_pkg::P_SELF;
               else if (|s_q.open)
                  s_d.pwr = ddr_pkg::P_PD_ACT;
               else
                  s_d.pwr = ddr_pkg::P_PD_PRE;
            end
            else if (rise && !link.chip_sel_n)
            begin
               s_d.last = cmd;
               case (cmd)
                  ddr_pkg::CMD_ACT:
                     s_d.open[ba] = 1'b1;
                  ddr_pkg::CMD_PRE:
                  begin
                     if (link.addr[ddr_pkg::AUTOPRE_POS])
                        s_d.open = 4'h0;
                     else
                        s_d.open[ba] = 1'b0;
                  end
                  ddr_pkg::CMD_RD, ddr_pkg::CMD_WR:
                  begin
                     s_d.bank = ba;
                     s_d.col = link.addr[1:0];
                     s_d.ap = link.addr[ddr_pkg::AUTOPRE_POS];
                     if (cmd == ddr_pkg::CMD_RD)
                        s_d.rd_st = 2'h1;
                     else
                        s_d.wr_st = 2'h1;
                  end
                  ddr_pkg::CMD_LMR:
                  begin
                     if (link.bank_sel_lo)
                        s_d.mode_ext = link.addr;
                     else
                        s_d.mode_base = link.addr;
                  end
                  default:
                     s_d.last = cmd;
               endcase
            end
         end
         ddr_pkg::P_PD_PRE, ddr_pkg::P_PD_ACT:
         begin
            if (rise && link.clk_gate_in)
               s_d.pwr = ddr_pkg::P_ON;
         end
         ddr_pkg::P_SELF:
         begin
            if (link.clk_gate_in)
               s_d.pwr = ddr_pkg::P_ON;
         end
         default:
            s_d.pwr = ddr_pkg::P_ON;
      endcase
      // Gate low stops bursts and drivers at once
      if (!link.clk_gate_in)
      begin
         s_d.dq_oe = 8'h00;
         s_d.dqs_oe = 8'h00;
         s_d.dqs_o = 8'h00;
         s_d.rd_st = 2'h0;
         s_d.wr_st = 2'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
         s_q.pwr <= ddr_pkg::P_ON;
         s_q.mode_base <= ddr_pkg::MODE_RST;
         s_q.mode_ext <= ddr_pkg::MODE_RST;
         s_q.last <= ddr_pkg::CMD_NOP;
      end
      else
         s_q <= s_d;
   end

   assign link.dq_dev_o = s_q.dq_o;
   assign link.dq_dev_oe = s_q.dq_oe;
   assign link.dqs_dev_o = s_q.dqs_o;
   assign link.dqs_dev_oe = s_q.dqs_oe;
   assign pwr_state = s_q.pwr;
   assign open_banks = s_q.open;
   assign base_mode = s_q.mode_base;
   assign ext_mode = s_q.mode_ext;
   assign last_cmd = s_q.last;
endmodule

// >>> core/ddr_ctrl_end.sv
// Memory controller end with APB command and status registers
`timescale 1ns/1ps
module ddr_ctrl_end (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Link
   ddr_link_if.ctrl         link
);
   typedef struct packed {
      ddr_pkg::cst_t    st;
      logic [1:0]       ph;
      logic             clk_p;
      logic             clk_n;
      logic             cke;
      logic             cs_n;
      logic [2:0]       cmd;
      logic [1:0]       ba;
      logic [12:0]      addr;
      logic             go;
      logic [5:0]       cmd_reg;
      logic [12:0]      addr_reg;
      logic             cke_req;
      logic [3:0][31:0] wd;
      logic [3:0][31:0] rd;
      logic [15:0]      mask;
      logic             rdone;
      logic [63:0]      dq_o;
      logic [7:0]       dq_oe;
      logic [7:0]       dqs_o;
      logic [7:0]       dqs_oe;
      logic [7:0]       dm;
      logic             dqs_prev;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
   } ctl_t;
   ctl_t s_q;
   ctl_t s_d;
   logic busy;
   logic wr_acc;
   logic in_wd;
   logic in_rd;
   logic is_rw;

   assign busy = s_q.go | (s_q.st != ddr_pkg::C_IDLE);
   assign wr_acc = psel & penable & s_q.pready & pwrite;
   assign in_wd = paddr[7:4] == ddr_pkg::REG_WD0[7:4];
   assign in_rd = paddr[7:4] == ddr_pkg::REG_RD0[7:4];
   assign is_rw = s_q.cmd_reg[2:0] == ddr_pkg::CMD_RD || s_q.cmd_reg[2:0] == ddr_pkg::CMD_WR;

   always_comb
   begin
      s_d = s_q;
      s_d.ph = s_q.ph + 2'h1;
      s_d.clk_p = ~s_d.ph[1];
      s_d.clk_n = s_d.ph[1];
      s_d.dqs_prev = link.data_strobes[0];
      // APB: setup cycle prepares the answer, access cycle completes
      s_d.pready = psel & ~penable;
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
         if (in_wd)
            s_d.prdata = s_q.wd[paddr[3:2]];
         else if (in_rd)
            s_d.prdata = s_q.rd[paddr[3:2]];
         else if (paddr == ddr_pkg::REG_CMD)
            s_d.prdata = {26'h0, s_q.cmd_reg};
         else if (paddr == ddr_pkg::REG_ADDR)
            s_d.prdata = {19'h0, s_q.addr_reg};
         else if (paddr == ddr_pkg::REG_CTRL)
            s_d.prdata = {31'h0, s_q.cke_req};
         else if (paddr == ddr_pkg::REG_STAT)
            s_d.prdata = {29'h0, s_q.cke, s_q.rdone, busy};
         else if (paddr == ddr_pkg::REG_MASK)
            s_d.prdata = {16'h0, s_q.mask};
         else
            s_d.pslverr = 1'b1;
      end
      else if (psel && !penable)
         s_d.pslverr = !(in_wd || in_rd || paddr == ddr_pkg::REG_CMD || paddr == ddr_pkg::REG_ADDR ||
                         paddr == ddr_pkg::REG_CTRL || paddr == ddr_pkg::REG_STAT || paddr == ddr_pkg::REG_MASK);
      if (wr_acc)
      begin
         if (in_wd)
            s_d.wd[paddr[3:2]] = pwdata;
         else if (paddr == ddr_pkg::REG_CMD && !busy)
         begin
            s_d.cmd_reg = pwdata[5:0];
            s_d.go = 1'b1;
         end
         else if (paddr == ddr_pkg::REG_ADDR)
            s_d.addr_reg = pwdata[12:0];
         else if (paddr == ddr_pkg::REG_CTRL)
            s_d.cke_req = pwdata[ddr_pkg::CTRL_CKE_BIT];
         else if (paddr == ddr_pkg::REG_STAT && pwdata[ddr_pkg::STAT_RDONE_BIT])
            s_d.rdone = 1'b0;
         else if (paddr == ddr_pkg::REG_MASK)
            s_d.mask = pwdata[15:0];
      end
      case (s_q.st)
         ddr_pkg::C_IDLE:
         begin
            if (s_q.ph == ddr_pkg::PH_LOAD)
            begin
               s_d.cke = s_q.cke_req;
               if (s_q.go)
               begin
                  s_d.go = 1'b0;
                  s_d.cs_n = s_q.cmd_reg[ddr_pkg::CMD_DESEL_BIT];
                  s_d.cmd = s_q.cmd_reg[2:0];
                  s_d.ba = s_q.cmd_reg[ddr_pkg::CMD_BANK_LSB +: 2];
                  s_d.addr = s_q.addr_reg;
                  s_d.st = ddr_pkg::C_CMD;
                  if (is_rw)
                     s_d.cke = 1'b1;
                  if (s_q.cmd_reg[2:0] == ddr_pkg::CMD_WR)
                     s_d.dqs_oe = 8'hff;
               end
            end
         end
         ddr_pkg::C_CMD:
         begin
            if (s_q.ph == ddr_pkg::PH_LOAD)
            begin
               s_d.cs_n = 1'b1;
               s_d.cmd = ddr_pkg::CMD_NOP;
               if (s_q.cs_n)
                  s_d.st = ddr_pkg::C_IDLE;
               else if (s_q.cmd == ddr_pkg::CMD_WR)
                  s_d.st = ddr_pkg::C_WR;
               else if (s_q.cmd == ddr_pkg::CMD_RD)
                  s_d.st = ddr_pkg::C_RD;
               else
                  s_d.st = ddr_pkg::C_IDLE;
               if (s_d.st == ddr_pkg::C_IDLE)
                  s_d.dqs_oe = 8'h00;
            end
         end
         ddr_pkg::C_WR:
         begin
            // Data changes at crossings, strobe toggles mid-bit
            if (s_q.ph == ddr_pkg::PH_BEAT0 && !s_q.dq_oe[0])
            begin
               s_d.dq_o = {s_q.wd[1], s_q.wd[0]};
               s_d.dq_oe = 8'hff;
               s_d.dm = s_q.mask[7:0];
            end
            else if (s_q.ph == ddr_pkg::PH_BEAT0)
            begin
               s_d.dq_oe = 8'h00;
               s_d.dqs_oe = 8'h00;
               s_d.dm = 8'h00;
               s_d.st = ddr_pkg::C_IDLE;
            end
            else if (s_q.dq_oe[0] && s_q.ph == ddr_pkg::PH_STB_HI)
               s_d.dqs_o = 8'hff;
            else if (s_q.dq_oe[0] && s_q.ph == ddr_pkg::PH_BEAT1)
            begin
               s_d.dq_o = {s_q.wd[3], s_q.wd[2]};
               s_d.dm = s_q.mask[15:8];
            end
            else if (s_q.dq_oe[0] && s_q.ph == ddr_pkg::PH_STB_LO)
               s_d.dqs_o = 8'h00;
         end
         ddr_pkg::C_RD:
         begin
            // Edge-aligned read beats taken on device strobe edges
            if (link.data_strobes[0] && !s_q.dqs_prev)
               {s_d.rd[1], s_d.rd[0]} = link.data_lines;
            else if (!link.data_strobes[0] && s_q.dqs_prev)
            begin
               {s_d.rd[3], s_d.rd[2]} = link.data_lines;
               s_d.rdone = 1'b1;
               s_d.st = ddr_pkg::C_IDLE;
            end
         end
         default:
            s_d.st = ddr_pkg::C_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
         s_q.st <= ddr_pkg::C_IDLE;
         s_q.clk_p <= 1'b1;
         s_q.cke <= ddr_pkg::CKE_RST;
         s_q.cke_req <= ddr_pkg::CKE_RST;
         s_q.cs_n <= 1'b1;
         s_q.cmd <= ddr_pkg::CMD_NOP;
         s_q.cmd_reg <= ddr_pkg::CMD_REG_RST;
      end
      else
         s_q <= s_d;
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign link.sys_clk_p = s_q.clk_p;
   assign link.sys_clk_n = s_q.clk_n;
   assign link.clk_gate_in = s_q.cke;
   assign link.chip_sel_n = s_q.cs_n;
   assign {link.row_strobe_n, link.col_strobe_n, link.write_en_n} = s_q.cmd;
   assign {link.bank_sel_hi, link.bank_sel_lo} = s_q.ba;
   assign link.addr = s_q.addr;
   assign link.dq_ctl_o = s_q.dq_o;
   assign link.dq_ctl_oe = s_q.dq_oe;
   assign link.dqs_ctl_o = s_q.dqs_o;
   assign link.dqs_ctl_oe = s_q.dqs_oe;
   assign link.write_byte_masks = s_q.dm;
endmodule

// >>> sim/ddr_link_chk.sv
// Assertions on the memory command link
`timescale 1ns/1ps
module ddr_link_chk (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Link pins
   input wire logic        sys_clk_p,
   input wire logic        sys_clk_n,
   input wire logic        clk_gate_in,
   input wire logic        chip_sel_n,
   input wire logic        row_strobe_n,
   input wire logic        col_strobe_n,
   input wire logic        write_en_n,
   input wire logic        bank_sel_lo,
   input wire logic        bank_sel_hi,
   input wire logic [12:0] addr,
   input wire logic [7:0]  dq_ctl_oe,
   input wire logic [7:0]  dq_dev_oe,
   input wire logic [7:0]  dqs_dev_oe,
   input wire logic [7:0]  data_strobes,
   input wire logic [7:0]  write_byte_masks
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [2:0] cmd;
   assign cmd = {row_strobe_n, col_strobe_n, write_en_n};
   sequence rd_beats;
      (data_strobes == 8'hff)[*2] ##1 (data_strobes == 8'h00 && dqs_dev_oe == 8'hff)[*2] ##1 (dqs_dev_oe == 8'h00);
   endsequence
   sequence wr_beats;
      (data_strobes == 8'h00) ##1 (data_strobes == 8'hff)[*2] ##1 (data_strobes == 8'h00) ##1 (dq_ctl_oe == 8'h00);
   endsequence
   clk_pair_a: assert property (sys_clk_n == !sys_clk_p)
      else $error("clock pair not complementary");
   link_period_a: assert property ($rose(sys_clk_p) |=> sys_clk_p ##1 (!sys_clk_p)[*2] ##1 sys_clk_p)
      else $error("link clock period wrong");
   pin_hold_a: assert property ($changed({chip_sel_n, cmd, bank_sel_hi, bank_sel_lo, addr}) |-> $fell(sys_clk_p))
      else $error("command pins moved off the falling phase");
   gate_rw_a: assert property (!chip_sel_n && (cmd == ddr_pkg::CMD_RD || cmd == ddr_pkg::CMD_WR) |-> clk_gate_in)
      else $error("access issued with clock gate low");
   gate_off_a: assert property (!clk_gate_in |=> dq_dev_oe == 8'h00 && dqs_dev_oe == 8'h00)
      else $error("device drives with clock gate low");
   rd_strobe_a: assert property ($rose(|dqs_dev_oe) |-> dq_dev_oe == 8'hff ##0 rd_beats)
      else $error("read strobes not edge aligned");
   wr_strobe_a: assert property ($rose(|dq_ctl_oe) |-> wr_beats)
      else $error("write strobes not centred");
   no_contend_a: assert property ((dq_ctl_oe & dq_dev_oe) == 8'h00)
      else $error("both ends drive data");
   mask_write_a: assert property (write_byte_masks != 8'h00 |-> dq_ctl_oe == 8'hff)
      else $error("mask raised outside write data");
endmodule

// >>> sim/ddr_module_command_pin_interface_tb.sv
// Testbench joining controller and module ends over APB
`timescale 1ns/1ps
module ddr_module_command_pin_interface_tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rq;
   logic        re;
   ddr_pkg::pwr_t pwr_state;
   logic [3:0]  open_banks;
   logic [12:0] base_mode;
   logic [12:0] ext_mode;
   logic [2:0]  last_cmd;
   int          mismatches = 0;
   int          n_compared = 0;
   logic [31:0] wd [4] = '{32'h11223344, 32'h55667788, 32'h99aabbcc, 32'hddeeff00};
   ddr_link_if link();
   ddr_ctrl_end i_ddr_ctrl_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   ddr_module_end i_ddr_module_end (.pclk(pclk), .presetn(presetn), .link(link), .pwr_state(pwr_state),
      .open_banks(open_banks), .base_mode(base_mode), .ext_mode(ext_mode), .last_cmd(last_cmd));
   ddr_link_chk i_ddr_link_chk (.pclk(pclk), .presetn(presetn), .sys_clk_p(link.sys_clk_p),
      .sys_clk_n(link.sys_clk_n), .clk_gate_in(link.clk_gate_in), .chip_sel_n(link.chip_sel_n),
      .row_strobe_n(link.row_strobe_n), .col_strobe_n(link.col_strobe_n), .write_en_n(link.write_en_n),
      .bank_sel_lo(link.bank_sel_lo), .bank_sel_hi(link.bank_sel_hi), .addr(link.addr),
      .dq_ctl_oe(link.dq_ctl_oe), .dq_dev_oe(link.dq_dev_oe), .dqs_dev_oe(link.dqs_dev_oe),
      .data_strobes(link.data_strobes), .write_byte_masks(link.write_byte_masks));
   always #10 pclk = ~pclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer, entered right after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk iff pready);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_stat(input int b, input logic v);
      for (int n = 0; n < 100; n++)
      begin
         apb(1'b0, ddr_pkg::REG_STAT, 32'h0);
         if (rq[b] === v)
            break;
      end
      repeat (8) @(posedge pclk);
   endtask
   task automatic cmd(input logic [31:0] a, input logic [31:0] c);
      apb(1'b1, ddr_pkg::REG_ADDR, a);
      apb(1'b1, ddr_pkg::REG_CMD, c);
      wait_stat(ddr_pkg::STAT_BUSY_BIT, 1'b0);
   endtask
   task automatic pwr_step(input logic g, input ddr_pkg::pwr_t exp);
      apb(1'b1, ddr_pkg::REG_CTRL, {31'h0, g});
      if (g)
         cmd(32'h0, 32'h07);
      repeat (12) @(posedge pclk);
      chk(32'(pwr_state), 32'(exp));
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      final_report();
   end
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ddr_pkg::REG_STAT, 32'h0);
      chk(rq, 32'h4);
      cmd(32'h0123, 32'h00);
      chk(32'(base_mode), 32'h0123);
      cmd(32'h0456, 32'h08);
      chk(32'(ext_mode), 32'h0456);
      cmd(32'h0005, 32'h13);
      chk(32'(open_banks), 32'h4);
      cmd(32'h0005, 32'h2b);
      chk(32'(open_banks), 32'h4);
      // Masked write to bank 2, then read back with auto-precharge
      for (int i = 0; i < 4; i++)
         apb(1'b1, ddr_pkg::REG_WD0 + 8'(4 * i), wd[i]);
      apb(1'b1, ddr_pkg::REG_MASK, 32'h1);
      cmd(32'h0000, 32'h14);
      cmd(32'h0400, 32'h15);
      wait_stat(ddr_pkg::STAT_RDONE_BIT, 1'b1);
      chk(32'(last_cmd), 32'(ddr_pkg::CMD_RD));
      chk(32'(open_banks), 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, ddr_pkg::REG_RD0 + 8'(4 * i), 32'h0);
         chk(rq, (i == 0) ? (wd[0] & 32'hffffff00) : wd[i]);
      end
      // Bank precharge, power-down states
      cmd(32'h0000, 32'h03);
      cmd(32'h0000, 32'h0b);
      cmd(32'h0000, 32'h02);
      chk(32'(open_banks), 32'h2);
      pwr_step(1'b0, ddr_pkg::P_PD_ACT);
      pwr_step(1'b1, ddr_pkg::P_ON);
      cmd(32'h0400, 32'h02);
      chk(32'(open_banks), 32'h0);
      pwr_step(1'b0, ddr_pkg::P_PD_PRE);
      apb(1'b0, ddr_pkg::REG_STAT, 32'h0);
      chk(rq & 32'h4, 32'h0);
      pwr_step(1'b1, ddr_pkg::P_ON);
      // Self refresh entry and edge-free exit
      // Start on a link clock rise so gate low and the refresh load together
      @(posedge link.sys_clk_p);
      apb(1'b1, ddr_pkg::REG_CTRL, 32'h0);
      apb(1'b1, ddr_pkg::REG_CMD, 32'h01);
      repeat (12) @(posedge pclk);
      chk(32'(pwr_state), 32'(ddr_pkg::P_SELF));
      apb(1'b1, ddr_pkg::REG_CTRL, 32'h1);
      repeat (6) @(posedge pclk);
      chk(32'(pwr_state), 32'(ddr_pkg::P_ON));
      apb(1'b0, 8'h40, 32'h0);
      chk({rq[30:0], re}, 32'h1);
      final_report();
   end
endmodule
